// File: logic/rfh_frontend_ctrl.sv
module rfh_frontend_ctrl (
	input  wire logic                       I_SYS_CLK,
	input  wire logic                       I_RESET,
	input  wire logic [rfh_pkg::ADDR_W-1:0] I_S_AXI_AWADDR,
	input  wire logic                       I_S_AXI_AWVALID,
	output logic                            O_S_AXI_AWREADY,
	input  wire logic [31:0]                I_S_AXI_WDATA,
	input  wire logic [3:0]                 I_S_AXI_WSTRB,
	input  wire logic                       I_S_AXI_WVALID,
	output logic                            O_S_AXI_WREADY,
	output logic [1:0]                      O_S_AXI_BRESP,
	output logic                            O_S_AXI_BVALID,
	input  wire logic                       I_S_AXI_BREADY,
	input  wire logic [rfh_pkg::ADDR_W-1:0] I_S_AXI_ARADDR,
	input  wire logic                       I_S_AXI_ARVALID,
	output logic                            O_S_AXI_ARREADY,
	output logic [31:0]                     O_S_AXI_RDATA,
	output logic [1:0]                      O_S_AXI_RRESP,
	output logic                            O_S_AXI_RVALID,
	input  wire logic                       I_S_AXI_RREADY,
	input  wire logic                       I_PA_POWERED,
	input  wire logic                       I_LNA_POWERED,
	input  wire logic                       I_PLL_LOCKED,
	input  wire logic [3:0]                 I_PUMP_CAL_RESULT,
	input  wire logic [4:0]                 I_OSC_ARRAY_CAL_RESULT,
	input  wire logic [5:0]                 I_OSC_CURRENT_CAL_RESULT,
	input  wire logic [7:0]                 I_FREQ_OFFSET_RESULT,
	output logic                            O_TX_AMP_ENABLE_OUT,
	output logic                            O_RX_AMP_ENABLE_OUT,
	output logic                            O_LOCK_PIN,
	output logic                            O_CHANNEL_SEL,
	output logic [23:0]                     O_SYNTH_FREQ,
	output logic [3:0]                      O_PUMP_SETTING,
	output logic [4:0]                      O_OSC_ARRAY_SETTING,
	output logic [5:0]                      O_OSC_CURRENT_SETTING
);

	typedef struct packed {
		logic                        aw_got;
		logic [rfh_pkg::IDX_W-1:0]   aw_idx;
		logic                        w_got;
		logic [7:0]                  w_data;
		logic                        w_lane0;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [7:0]                  rdata;
		logic [7:0]                  main_ctrl;
		logic [7:0]                  iface;
		logic [2:0][7:0]             freq0;
		logic [2:0][7:0]             freq1;
		logic [7:0]                  lock_pin_source_ctrl;
		logic [7:0]                  pump_override_value;
		logic [7:0]                  array_override_ctrl;
		logic [7:0]                  cal_current_override_ctrl;
		logic                        tx_en;
		logic                        rx_en;
		logic                        lock_pin;
		logic                        chan_sel;
		logic [23:0]                 synth_freq;
		logic [3:0]                  pump_set;
		logic [4:0]                  array_set;
		logic [5:0]                  cur_set;
	} rfh_state_s;

	rfh_state_s st_reg;
	rfh_state_s st_next;

	logic                      do_write;
	logic                      wr_ok;
	logic                      rd_ok;
	logic [7:0]                rd_val;
	logic [rfh_pkg::IDX_W-1:0] ar_idx;
	logic                      tx_follow;
	logic                      rx_follow;
	logic                      tx_pol;
	logic                      rx_pol;
	logic [3:0]                lock_sel;

	assign ar_idx = I_S_AXI_ARADDR[rfh_pkg::IDX_W+1:2];

	// Handshake outputs are combinational from registered state
	assign O_S_AXI_AWREADY = !st_reg.aw_got && !st_reg.bvalid;
	assign O_S_AXI_WREADY  = !st_reg.w_got && !st_reg.bvalid;
	assign O_S_AXI_ARREADY = !st_reg.rvalid;
	assign O_S_AXI_BVALID  = st_reg.bvalid;
	assign O_S_AXI_BRESP   = st_reg.bresp;
	assign O_S_AXI_RVALID  = st_reg.rvalid;
	assign O_S_AXI_RRESP   = st_reg.rresp;
	assign O_S_AXI_RDATA   = {24'h000000, st_reg.rdata};

	assign O_TX_AMP_ENABLE_OUT   = st_reg.tx_en;
	assign O_RX_AMP_ENABLE_OUT   = st_reg.rx_en;
	assign O_LOCK_PIN            = st_reg.lock_pin;
	assign O_CHANNEL_SEL         = st_reg.chan_sel;
	assign O_SYNTH_FREQ          = st_reg.synth_freq;
	assign O_PUMP_SETTING        = st_reg.pump_set;
	assign O_OSC_ARRAY_SETTING   = st_reg.array_set;
	assign O_OSC_CURRENT_SETTING = st_reg.cur_set;

	assign do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

	// Decode of the write target
	always_comb begin
		case (st_reg.aw_idx)
			rfh_pkg::IDX_MAIN,
			rfh_pkg::IDX_INTERFACE,
			rfh_pkg::IDX_SOFT_RST,
			rfh_pkg::IDX_FREQ0_HI,
			rfh_pkg::IDX_FREQ0_MID,
			rfh_pkg::IDX_FREQ0_LO,
			rfh_pkg::IDX_FREQ1_HI,
			rfh_pkg::IDX_FREQ1_MID,
			rfh_pkg::IDX_FREQ1_LO,
			rfh_pkg::IDX_LOCK,
			rfh_pkg::IDX_PUMP_OVERRIDE_VALUE,
			rfh_pkg::IDX_ARRAY_OVERRIDE_CTRL,
			rfh_pkg::IDX_CAL_CURRENT_OVERRIDE_CTRL: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Read mux; status results come straight from the calibration logic
	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 8'h00;
		case (ar_idx)
			rfh_pkg::IDX_MAIN: rd_val = st_reg.main_ctrl;
			rfh_pkg::IDX_INTERFACE: rd_val = st_reg.iface;
			rfh_pkg::IDX_SOFT_RST: rd_val = 8'h00;
			rfh_pkg::IDX_FREQ0_HI: rd_val = st_reg.freq0[2];
			rfh_pkg::IDX_FREQ0_MID: rd_val = st_reg.freq0[1];
			rfh_pkg::IDX_FREQ0_LO: rd_val = st_reg.freq0[0];
			rfh_pkg::IDX_FREQ1_HI: rd_val = st_reg.freq1[2];
			rfh_pkg::IDX_FREQ1_MID: rd_val = st_reg.freq1[1];
			rfh_pkg::IDX_FREQ1_LO: rd_val = st_reg.freq1[0];
			rfh_pkg::IDX_LOCK: rd_val = st_reg.lock_pin_source_ctrl;
			rfh_pkg::IDX_PUMP_OVERRIDE_VALUE: rd_val = st_reg.pump_override_value;
			rfh_pkg::IDX_ARRAY_OVERRIDE_CTRL: rd_val = st_reg.array_override_ctrl;
			rfh_pkg::IDX_CAL_CURRENT_OVERRIDE_CTRL: rd_val = st_reg.cal_current_override_ctrl;
			rfh_pkg::IDX_OFFSET: rd_val = I_FREQ_OFFSET_RESULT;
			rfh_pkg::IDX_HOP_CAL_READBACK_PUMP: rd_val = {4'h0, I_PUMP_CAL_RESULT};
			rfh_pkg::IDX_HOP_CAL_READBACK_ARRAY: rd_val = {3'h0, I_OSC_ARRAY_CAL_RESULT};
			rfh_pkg::IDX_HOP_CAL_READBACK_CURRENT: rd_val = {2'h0, I_OSC_CURRENT_CAL_RESULT};
			default: rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		st_next = st_reg;

		// Write address and data are taken in either order
		if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) begin
			st_next.aw_got = 1'b1;
			st_next.aw_idx = I_S_AXI_AWADDR[rfh_pkg::IDX_W+1:2];
		end
		if (I_S_AXI_WVALID && O_S_AXI_WREADY) begin
			st_next.w_got   = 1'b1;
			st_next.w_data  = I_S_AXI_WDATA[7:0];
			st_next.w_lane0 = I_S_AXI_WSTRB[0];
		end
		if (st_reg.bvalid && I_S_AXI_BREADY) begin
			st_next.bvalid = 1'b0;
		end

		if (do_write) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = wr_ok ? rfh_pkg::RESP_OKAY : rfh_pkg::RESP_SLVERR;
			// Only byte lane 0 holds register bits
			if (st_reg.w_lane0) begin
				case (st_reg.aw_idx)
					rfh_pkg::IDX_MAIN: st_next.main_ctrl = st_reg.w_data;
					rfh_pkg::IDX_INTERFACE: st_next.iface = st_reg.w_data;
					// The idle set may be rewritten at any time for the next hop
					rfh_pkg::IDX_FREQ0_HI: st_next.freq0[2] = st_reg.w_data;
					rfh_pkg::IDX_FREQ0_MID: st_next.freq0[1] = st_reg.w_data;
					rfh_pkg::IDX_FREQ0_LO: st_next.freq0[0] = st_reg.w_data;
					rfh_pkg::IDX_FREQ1_HI: st_next.freq1[2] = st_reg.w_data;
					rfh_pkg::IDX_FREQ1_MID: st_next.freq1[1] = st_reg.w_data;
					rfh_pkg::IDX_FREQ1_LO: st_next.freq1[0] = st_reg.w_data;
					rfh_pkg::IDX_LOCK: st_next.lock_pin_source_ctrl = st_reg.w_data;
					rfh_pkg::IDX_PUMP_OVERRIDE_VALUE: st_next.pump_override_value = st_reg.w_data;
					rfh_pkg::IDX_ARRAY_OVERRIDE_CTRL: st_next.array_override_ctrl = st_reg.w_data;
					rfh_pkg::IDX_CAL_CURRENT_OVERRIDE_CTRL: st_next.cal_current_override_ctrl = st_reg.w_data;
					rfh_pkg::IDX_SOFT_RST: begin
						if (st_reg.w_data[rfh_pkg::SOFT_RST_BIT]) begin
							st_next.main_ctrl                 = rfh_pkg::RST_MAIN;
							st_next.iface                     = rfh_pkg::RST_INTERFACE;
							st_next.freq0                     = {3{rfh_pkg::RST_FREQ}};
							st_next.freq1                     = {3{rfh_pkg::RST_FREQ}};
							st_next.lock_pin_source_ctrl      = rfh_pkg::RST_LOCK;
							st_next.pump_override_value       = rfh_pkg::RST_TEST;
							st_next.array_override_ctrl       = rfh_pkg::RST_TEST;
							st_next.cal_current_override_ctrl = rfh_pkg::RST_TEST;
						end
					end
					default: begin
					end
				endcase
			end
		end

		if (st_reg.rvalid && I_S_AXI_RREADY) begin
			st_next.rvalid = 1'b0;
		end
		if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd_val;
			st_next.rresp  = rd_ok ? rfh_pkg::RESP_OKAY : rfh_pkg::RESP_SLVERR;
		end

		// Pins follow registered config, so a write shows one clock later with no glitch
		if (tx_follow) begin
			st_next.tx_en = I_PA_POWERED ? tx_pol : !tx_pol;
		end else begin
			st_next.tx_en = tx_pol;
		end
		if (rx_follow) begin
			st_next.rx_en = I_LNA_POWERED ? rx_pol : !rx_pol;
		end else begin
			st_next.rx_en = rx_pol;
		end

		case (lock_sel)
			rfh_pkg::LOCK_SEL_LOW: st_next.lock_pin = 1'b0;
			rfh_pkg::LOCK_SEL_HIGH: st_next.lock_pin = 1'b1;
			default: st_next.lock_pin = I_PLL_LOCKED;
		endcase

		// Channel change takes effect one clock after the select bit is stored
		st_next.chan_sel   = st_reg.main_ctrl[rfh_pkg::MAIN_CHAN_BIT];
		st_next.synth_freq = st_reg.main_ctrl[rfh_pkg::MAIN_CHAN_BIT] ?
			st_reg.freq1 : st_reg.freq0;

		// Overrides replace the calibrated values only while enabled
		st_next.pump_set = st_reg.array_override_ctrl[rfh_pkg::T2_PUMP_OVR_EN] ?
			st_reg.pump_override_value[3:0] : I_PUMP_CAL_RESULT;
		st_next.array_set = st_reg.array_override_ctrl[rfh_pkg::T2_ARRAY_OVR_EN] ?
			st_reg.array_override_ctrl[4:0] : I_OSC_ARRAY_CAL_RESULT;
		st_next.cur_set = st_reg.cal_current_override_ctrl[rfh_pkg::T3_CUR_OVR_EN] ?
			st_reg.cal_current_override_ctrl[5:0] : I_OSC_CURRENT_CAL_RESULT;
	end

	assign tx_follow = st_reg.iface[rfh_pkg::IF_TX_FOLLOW];
	assign rx_follow = st_reg.iface[rfh_pkg::IF_RX_FOLLOW];
	assign tx_pol    = st_reg.iface[rfh_pkg::IF_TX_POL];
	assign rx_pol    = st_reg.iface[rfh_pkg::IF_RX_POL];
	assign lock_sel  = st_reg.lock_pin_source_ctrl[3:0];

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			st_reg                           <= '0;
			st_reg.bresp                     <= rfh_pkg::RESP_OKAY;
			st_reg.rresp                     <= rfh_pkg::RESP_OKAY;
			st_reg.main_ctrl                 <= rfh_pkg::RST_MAIN;
			st_reg.iface                     <= rfh_pkg::RST_INTERFACE;
			st_reg.freq0                     <= {3{rfh_pkg::RST_FREQ}};
			st_reg.freq1                     <= {3{rfh_pkg::RST_FREQ}};
			st_reg.lock_pin_source_ctrl      <= rfh_pkg::RST_LOCK;
			st_reg.pump_override_value       <= rfh_pkg::RST_TEST;
			st_reg.array_override_ctrl       <= rfh_pkg::RST_TEST;
			st_reg.cal_current_override_ctrl <= rfh_pkg::RST_TEST;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule // rfh_frontend_ctrl

// File: logic/rfh_pkg.sv
// Overview of operation
// - With tx follow set, the tx amp enable pin is active while the internal PA is on, registered one clock behind it.
// - With rx follow set, the rx amp enable pin is active while the internal LNA is on, registered one clock behind it.
// - In follow mode each polarity bit sets the active level of its enable pin.
// - With a follow bit clear, its enable pin is driven statically to its polarity bit.
// - The lock pin is low when the lock source field is 0000 and high when it is 0001.
// - Two channel frequency sets exist and the idle set stays writable while the other is used.
// - Bit 6 of the main control register picks the frequency set, and writing it changes channel.
// - The pump, oscillator array and oscillator current calibration results are readable.
// - Test registers hold override values at the result positions, enabled by their bits 5 and 6.
// - The measured carrier frequency offset is readable in a status register.
// - A programmed reset returns every configuration register, test registers too, to default.
package rfh_pkg;

	localparam int ADDR_W = 12;
	localparam int IDX_W  = 8;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_MAIN      = 8'h00;
	localparam logic [7:0] IDX_INTERFACE = 8'h01;
	localparam logic [7:0] IDX_SOFT_RST  = 8'h02;
	localparam logic [7:0] IDX_FREQ0_HI  = 8'h04;
	localparam logic [7:0] IDX_FREQ0_MID = 8'h05;
	localparam logic [7:0] IDX_FREQ0_LO  = 8'h06;
	localparam logic [7:0] IDX_FREQ1_HI  = 8'h08;
	localparam logic [7:0] IDX_FREQ1_MID = 8'h09;
	localparam logic [7:0] IDX_FREQ1_LO  = 8'h0a;
	localparam logic [7:0] IDX_LOCK      = 8'h15;
	localparam logic [7:0] IDX_PUMP_OVERRIDE_VALUE     = 8'h21;
	localparam logic [7:0] IDX_ARRAY_OVERRIDE_CTRL     = 8'h22;
	localparam logic [7:0] IDX_CAL_CURRENT_OVERRIDE_CTRL     = 8'h23;
	localparam logic [7:0] IDX_OFFSET    = 8'h43;
	localparam logic [7:0] IDX_HOP_CAL_READBACK_PUMP   = 8'h45;
	localparam logic [7:0] IDX_HOP_CAL_READBACK_ARRAY   = 8'h46;
	localparam logic [7:0] IDX_HOP_CAL_READBACK_CURRENT   = 8'h47;

	// Field positions
	localparam int MAIN_CHAN_BIT   = 6;
	localparam int IF_TX_FOLLOW    = 0;
	localparam int IF_RX_FOLLOW    = 1;
	localparam int IF_TX_POL       = 2;
	localparam int IF_RX_POL       = 3;
	localparam int SOFT_RST_BIT    = 0;
	localparam int T2_ARRAY_OVR_EN = 5;
	localparam int T2_PUMP_OVR_EN  = 6;
	localparam int T3_CUR_OVR_EN   = 6;

	localparam logic [3:0] LOCK_SEL_LOW  = 4'h0;
	localparam logic [3:0] LOCK_SEL_HIGH = 4'h1;

	// Reset values
	localparam logic [7:0] RST_MAIN      = 8'h00;
	localparam logic [7:0] RST_INTERFACE = 8'h00;
	localparam logic [7:0] RST_FREQ      = 8'h00;
	localparam logic [7:0] RST_LOCK      = 8'h00;
	localparam logic [7:0] RST_TEST      = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rfh_pkg

// File: testbench/rfh_amp_model.sv
module rfh_amp_model (
	input  wire logic i_enable_pin,
	input  wire logic i_active_high,
	output logic      o_amp_on
);
	timeunit 1ns;
	timeprecision 1ns;
	// The amplifier's strap decides which enable level switches it on
	assign o_amp_on = (i_enable_pin == i_active_high);
endmodule // rfh_amp_model

// File: testbench/rfh_frontend_ctrl_properties.sv
module rfh_frontend_ctrl_properties (
	input wire logic                       I_SYS_CLK,
	input wire logic                       I_RESET,
	input wire logic                       I_S_AXI_AWVALID,
	input wire logic                       O_S_AXI_AWREADY,
	input wire logic                       I_S_AXI_WVALID,
	input wire logic                       O_S_AXI_WREADY,
	input wire logic [1:0]                 O_S_AXI_BRESP,
	input wire logic                       O_S_AXI_BVALID,
	input wire logic                       I_S_AXI_BREADY,
	input wire logic [rfh_pkg::ADDR_W-1:0] I_S_AXI_ARADDR,
	input wire logic                       I_S_AXI_ARVALID,
	input wire logic                       O_S_AXI_ARREADY,
	input wire logic [31:0]                O_S_AXI_RDATA,
	input wire logic                       O_S_AXI_RVALID,
	input wire logic                       I_S_AXI_RREADY,
	input wire logic [3:0]                 I_PUMP_CAL_RESULT,
	input wire logic [5:0]                 I_OSC_CURRENT_CAL_RESULT,
	input wire logic [7:0]                 I_FREQ_OFFSET_RESULT
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rd_idx_reg;
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RESET);
	// Remembers which register the pending read addresses
	always_ff @(posedge I_SYS_CLK) begin
		if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) begin
			rd_idx_reg <= I_S_AXI_ARADDR[9:2];
		end
	end
	a_bresp_held: assert property (O_S_AXI_BVALID && !I_S_AXI_BREADY
		|=> O_S_AXI_BVALID && $stable(O_S_AXI_BRESP)) else $error("write response dropped");
	a_rdata_held: assert property (O_S_AXI_RVALID && !I_S_AXI_RREADY
		|=> O_S_AXI_RVALID && $stable(O_S_AXI_RDATA)) else $error("read data dropped");
	a_arready_free: assert property (O_S_AXI_ARREADY == !O_S_AXI_RVALID)
		else $error("read address ready wrong");
	a_read_latency: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID)
		else $error("read answer late");
	a_write_latency: assert property (I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID
		&& O_S_AXI_WREADY |=> !O_S_AXI_AWREADY && !O_S_AXI_WREADY ##1 O_S_AXI_BVALID)
		else $error("write answer late");
	a_pump_readback: assert property ($rose(O_S_AXI_RVALID) && rd_idx_reg == 8'h45
		|-> O_S_AXI_RDATA[3:0] == $past(I_PUMP_CAL_RESULT)) else $error("pump result wrong");
	a_current_readback: assert property ($rose(O_S_AXI_RVALID) && rd_idx_reg == 8'h47
		|-> O_S_AXI_RDATA[5:0] == $past(I_OSC_CURRENT_CAL_RESULT)) else $error("current wrong");
	a_offset_readback: assert property ($rose(O_S_AXI_RVALID) && rd_idx_reg == 8'h43
		|-> O_S_AXI_RDATA[7:0] == $past(I_FREQ_OFFSET_RESULT)) else $error("offset wrong");
endmodule // rfh_frontend_ctrl_properties

// File: testbench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                       I_SYS_CLK = 1'b0, I_RESET = 1'b1;
	logic [rfh_pkg::ADDR_W-1:0] I_S_AXI_AWADDR = '0, I_S_AXI_ARADDR = '0;
	logic                       I_S_AXI_AWVALID = 1'b0, I_S_AXI_WVALID = 1'b0;
	logic                       I_S_AXI_BREADY = 1'b0, I_S_AXI_ARVALID = 1'b0, I_S_AXI_RREADY = 1'b0;
	logic                       I_PA_POWERED = 1'b0, I_LNA_POWERED = 1'b0, I_PLL_LOCKED = 1'b0;
	logic [31:0]                I_S_AXI_WDATA = '0, O_S_AXI_RDATA, v, w;
	logic [3:0]                 I_S_AXI_WSTRB = 4'hf, I_PUMP_CAL_RESULT = '0, O_PUMP_SETTING;
	logic [4:0]                 I_OSC_ARRAY_CAL_RESULT = '0, O_OSC_ARRAY_SETTING;
	logic [5:0]                 I_OSC_CURRENT_CAL_RESULT = '0, O_OSC_CURRENT_SETTING;
	logic [7:0]                 I_FREQ_OFFSET_RESULT = '0;
	logic                       O_S_AXI_AWREADY, O_S_AXI_WREADY, O_S_AXI_BVALID, O_S_AXI_ARREADY;
	logic                       O_S_AXI_RVALID, O_TX_AMP_ENABLE_OUT, O_RX_AMP_ENABLE_OUT;
	logic                       O_LOCK_PIN, O_CHANNEL_SEL, tx_on, rx_on;
	logic [1:0]                 O_S_AXI_BRESP, O_S_AXI_RRESP;
	logic [23:0]                O_SYNTH_FREQ, f0, f1;
	logic [3:0]                 cfg = '0;
	logic [7:0]                 idx_tab [6] = '{8'h00, 8'h01, 8'h15, 8'h21, 8'h22, 8'h23};
	int                         seed, failures = 0, tests_run = 0;

	rfh_frontend_ctrl rfh_frontend_ctrl_inst (.*);
	rfh_amp_model tx_amp_inst (.i_enable_pin(O_TX_AMP_ENABLE_OUT), .i_active_high(cfg[2]),
		.o_amp_on(tx_on));
	rfh_amp_model rx_amp_inst (.i_enable_pin(O_RX_AMP_ENABLE_OUT), .i_active_high(cfg[3]),
		.o_amp_on(rx_on));

	initial begin
		forever #25 I_SYS_CLK = ~I_SYS_CLK;
	end

	task automatic final_report;
		if (failures == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic guard(input int n);
		if (n >= 50) begin
			chk("handshake", 32'h0, 32'(n));
			final_report();
		end
	endtask

	// Starts one edge late so a ready line is never lowered and raised in one step
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge I_SYS_CLK);
		I_S_AXI_AWADDR <= {2'b00, idx, 2'b00};
		I_S_AXI_WDATA <= {24'h0, d};
		I_S_AXI_AWVALID <= 1'b1;
		I_S_AXI_WVALID <= 1'b1;
		I_S_AXI_BREADY <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge I_SYS_CLK);
			if (O_S_AXI_AWREADY) I_S_AXI_AWVALID <= 1'b0;
			if (O_S_AXI_WREADY) I_S_AXI_WVALID <= 1'b0;
			if (O_S_AXI_BVALID) break;
		end
		guard(n);
		chk("bresp", 32'(er), 32'(O_S_AXI_BRESP));
		I_S_AXI_BREADY <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
		int n;
		@(posedge I_SYS_CLK);
		I_S_AXI_ARADDR <= {2'b00, idx, 2'b00};
		I_S_AXI_ARVALID <= 1'b1;
		I_S_AXI_RREADY <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge I_SYS_CLK);
			if (O_S_AXI_ARREADY) I_S_AXI_ARVALID <= 1'b0;
			if (O_S_AXI_RVALID) break;
		end
		guard(n);
		chk("rdata", {24'h0, e}, O_S_AXI_RDATA);
		chk("rresp", 32'(er), 32'(O_S_AXI_RRESP));
		I_S_AXI_RREADY <= 1'b0;
	endtask

	function automatic logic pin_exp(input logic follow, input logic pol, input logic on);
		return follow ? (on ? pol : !pol) : pol;
	endfunction

	initial begin
		seed = 93669;
		repeat (6) @(posedge I_SYS_CLK);
		I_RESET <= 1'b0;
		foreach (idx_tab[k]) rd(idx_tab[k], 8'h00, 2'h0);
		for (int i = 0; i < 32; i++) begin
			v = $random(seed);
			cfg <= i[3:0];
			I_PA_POWERED <= v[4];
			I_LNA_POWERED <= v[5];
			wr(8'h01, {4'h0, i[3:0]}, 2'h0);
			#1;
			chk("tx_pin", 32'(pin_exp(cfg[0], cfg[2], v[4])), 32'(O_TX_AMP_ENABLE_OUT));
			chk("rx_pin", 32'(pin_exp(cfg[1], cfg[3], v[5])), 32'(O_RX_AMP_ENABLE_OUT));
			if (cfg[0]) chk("tx_amp", 32'(v[4]), 32'(tx_on));
			if (cfg[1]) chk("rx_amp", 32'(v[5]), 32'(rx_on));
		end
		for (int k = 0; k < 2; k++) begin
			wr(8'h15, 8'(k), 2'h0);
			#1;
			chk("lock_pin", 32'(k), 32'(O_LOCK_PIN));
		end
		I_PA_POWERED <= 1'b0;
		f0 = 24'($random(seed));
		f1 = 24'($random(seed));
		for (int j = 0; j < 3; j++) wr(8'h04 + 8'(j), f0[23-8*j -: 8], 2'h0);
		for (int j = 0; j < 3; j++) wr(8'h08 + 8'(j), f1[23-8*j -: 8], 2'h0);
		#1;
		chk("synth", 32'(f0), 32'(O_SYNTH_FREQ));
		wr(8'h00, 8'h40, 2'h0);
		#1;
		chk("chan", 32'h1, 32'(O_CHANNEL_SEL));
		chk("synth", 32'(f1), 32'(O_SYNTH_FREQ));
		w = $random(seed);
		I_PUMP_CAL_RESULT <= w[3:0];
		I_OSC_ARRAY_CAL_RESULT <= w[8:4];
		I_OSC_CURRENT_CAL_RESULT <= w[14:9];
		I_FREQ_OFFSET_RESULT <= w[31:24];
		v = $random(seed);
		wr(8'h21, {4'h0, v[3:0]}, 2'h0);
		wr(8'h22, {3'b011, v[8:4]}, 2'h0);
		wr(8'h23, {2'b01, v[14:9]}, 2'h0);
		#1;
		chk("pump", 32'(v[3:0]), 32'(O_PUMP_SETTING));
		chk("array", 32'(v[8:4]), 32'(O_OSC_ARRAY_SETTING));
		chk("current", 32'(v[14:9]), 32'(O_OSC_CURRENT_SETTING));
		wr(8'h22, 8'h00, 2'h0);
		wr(8'h23, 8'h00, 2'h0);
		#1;
		chk("pump", 32'(w[3:0]), 32'(O_PUMP_SETTING));
		chk("array", 32'(w[8:4]), 32'(O_OSC_ARRAY_SETTING));
		chk("current", 32'(w[14:9]), 32'(O_OSC_CURRENT_SETTING));
		rd(8'h45, {4'h0, w[3:0]}, 2'h0);
		rd(8'h46, {3'h0, w[8:4]}, 2'h0);
		rd(8'h47, {2'h0, w[14:9]}, 2'h0);
		rd(8'h43, w[31:24], 2'h0);
		wr(8'h15, 8'h02, 2'h0);
		I_PLL_LOCKED <= 1'b1;
		repeat (2) @(posedge I_SYS_CLK);
		#1;
		chk("lock_pin", 32'h1, 32'(O_LOCK_PIN));
		I_PA_POWERED <= 1'b1;
		wr(8'h30, 8'h5a, 2'h2);
		rd(8'h30, 8'h00, 2'h2);
		wr(8'h45, 8'h5a, 2'h2);
		wr(8'h02, 8'h01, 2'h0);
		// Lane 0 disabled: the write is answered but must leave the register alone
		I_S_AXI_WSTRB <= 4'h0;
		wr(8'h21, 8'h0f, 2'h0);
		I_S_AXI_WSTRB <= 4'hf;
		foreach (idx_tab[k]) rd(idx_tab[k], 8'h00, 2'h0);
		chk("tx_pin", 32'h0, 32'(O_TX_AMP_ENABLE_OUT));
		final_report();
	end
endmodule // tb

bind rfh_frontend_ctrl rfh_frontend_ctrl_properties rfh_frontend_ctrl_properties_inst (.*);
